// ---- hw/vdsc_core.sv ----
module vdsc_core
  import vdsc_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = SHORT_POLL_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // Host GPIO pins
  input  wire logic                         enable_pin_i,
  input  wire logic                         trigger_input_pin_i,
  // Register port from the serial slave engine
  input  wire vdsc_reg_req_t                reg_req_i,
  output logic                              reg_ack_o,
  output logic          [7:0]               reg_rdata_o,
  // Analog monitors
  input  wire logic                         over_temp_i,
  input  wire logic                         short_det_i,
  input  wire logic                         reg_short_i,
  input  wire logic     [7:0]               supply_meas_i,
  input  wire logic                         supply_valid_i,
  // One-time-programmable configuration storage
  input  wire logic     [CFG_COUNT-1:0]     otp_prog_i,
  input  wire logic     [CFG_COUNT-1:0][7:0] otp_data_i,
  // Playback engine
  input  wire logic                         proc_done_i,
  output vdsc_proc_t                        proc_o,
  output logic                              drive_en_o,
  output vdsc_pstate_t                      power_state_o
);

  localparam logic [15:0] POLL_LAST = 16'(POLL_CYCLES - 1);

  // Synchronised pins and monitors.
  logic [4:0] pins_s;
  logic       en_s;
  logic       trig_s;
  logic       ot_s;
  logic       short_s;
  logic       reg_short_s;
  logic       trig_rise;
  logic       trig_fall;

  vdsc_sync #(.WIDTH(5)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i ({reg_short_i, short_det_i, over_temp_i, trigger_input_pin_i, enable_pin_i}),
    .sync_o  (pins_s)
  );

  assign en_s        = pins_s[0];
  assign trig_s      = pins_s[1];
  assign ot_s        = pins_s[2];
  assign short_s     = pins_s[3];
  assign reg_short_s = pins_s[4];

  vdsc_trig u_trig (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (trig_s),
    .rise_o  (trig_rise),
    .fall_o  (trig_fall)
  );

  // Registers.
  logic [2:0]   mode_q;
  logic         standby_q;
  logic         dev_reset_q;
  logic         go_q;
  logic         go_d;
  logic         input_sel_q;
  logic [7:0]   cfg_q [CFG_COUNT];
  logic [7:0]   supply_q;
  logic         ot_flag_q;
  logic         short_flag_q;
  logic         block_q;
  logic         fault_q;
  logic         restart_q;
  logic [15:0]  poll_cnt_q;
  logic         run_q;
  logic         run_d;
  logic         run_prev_q;
  vdsc_kind_t   kind_q;
  vdsc_kind_t   kind_d;
  vdsc_pstate_t pstate_d;
  logic [7:0]   rdata_d;
  logic [7:0]   read_mux;

  // Mode decoding.
  function automatic vdsc_kind_t mode_kind(input logic [2:0] mode, input logic stream);
    vdsc_kind_t k;
    k = PROC_NONE;
    unique case (mode)
      MODE_INT_TRIG, MODE_EDGE_TRIG, MODE_LEVEL_TRIG: k = PROC_PLAY;
      MODE_ANALOG_PWM, MODE_REALTIME:                 k = stream ? PROC_STREAM : PROC_PLAY;
      MODE_DIAG:                                      k = PROC_DIAG;
      MODE_CAL:                                       k = PROC_CAL;
      default:                                        k = PROC_NONE;
    endcase
    return k;
  endfunction

  // Register port decode; without enable nothing is written or read.
  wire       wr_ok       = reg_req_i.wr & en_s;
  wire       hit_mode    = reg_req_i.addr == ADDR_MODE;
  wire       hit_fire    = reg_req_i.addr == ADDR_FIRE;
  wire       hit_input   = reg_req_i.addr == ADDR_INPUT_CTRL;
  wire       hit_cfg     = (reg_req_i.addr >= ADDR_CFG_FIRST) && (reg_req_i.addr <= ADDR_CFG_LAST);
  wire [7:0] cfg_off     = reg_req_i.addr - ADDR_CFG_FIRST;
  wire [2:0] cfg_idx     = cfg_off[2:0];
  wire       mode_wr     = wr_ok & hit_mode;
  wire       fire_wr     = wr_ok & hit_fire;

  // Device reset, regulator short and short-recovery restart act as power-up.
  wire soft_rst    = dev_reset_q | reg_short_s | restart_q;
  wire clr         = ~rst_n_i | soft_rst;

  // Go signal: fire bit, or a streaming mode, gated by power and fault state.
  wire ext_edge    = mode_q == MODE_EDGE_TRIG;
  wire ext_level   = mode_q == MODE_LEVEL_TRIG;
  wire stream_mode = (mode_q == MODE_REALTIME) || ((mode_q == MODE_ANALOG_PWM) && input_sel_q);
  wire analog_mode = (mode_q == MODE_ANALOG_PWM) && !input_sel_q;
  wire run_allowed = en_s & ~standby_q & ~fault_q & ~ot_s & ~block_q;
  wire go_signal   = go_q | stream_mode | analog_mode;
  wire proc_end    = proc_done_i & run_q & (kind_q != PROC_STREAM);
  wire short_hit   = short_s & run_q;
  wire short_early = short_hit & ~run_prev_q;
  wire poll_wrap   = fault_q && (poll_cnt_q == POLL_LAST);

  always_comb begin
    go_d = go_q;
    if (proc_end) begin
      go_d = 1'b0;
    end
    if (fire_wr) begin
      go_d = reg_req_i.wdata[FIRE_BIT];
    end
    if (ext_edge && trig_rise) begin
      go_d = ~go_q;
    end
    if (ext_level) begin
      go_d = trig_s;
    end
    if (standby_q) begin
      go_d = 1'b0;
    end
  end

  assign kind_d = mode_kind(mode_q, stream_mode | analog_mode);
  assign run_d  = run_allowed & go_signal & (kind_d != PROC_NONE) & ~short_hit;

  always_comb begin
    if (!en_s) begin
      pstate_d = PS_SHUTDOWN;
    end else if (fault_q) begin
      pstate_d = PS_FAULT;
    end else if (standby_q) begin
      pstate_d = PS_STANDBY;
    end else if (run_d) begin
      pstate_d = PS_ACTIVE;
    end else begin
      pstate_d = PS_READY;
    end
  end

  always_comb begin
    read_mux = 8'h00;
    if (reg_req_i.addr == ADDR_STATUS) begin
      read_mux[STAT_SHORT_BIT]     = short_flag_q;
      read_mux[STAT_OVER_TEMP_BIT] = ot_flag_q;
    end else if (hit_mode) begin
      read_mux[MODE_FIELD_MSB:MODE_FIELD_LSB] = mode_q;
      read_mux[MODE_STANDBY_BIT]              = standby_q;
      read_mux[MODE_RESET_BIT]                = dev_reset_q;
    end else if (hit_fire) begin
      read_mux[FIRE_BIT] = go_q;
    end else if (hit_input) begin
      read_mux[INPUT_SEL_BIT] = input_sel_q;
    end else if (hit_cfg) begin
      read_mux = cfg_q[cfg_idx];
    end else if (reg_req_i.addr == ADDR_SUPPLY) begin
      read_mux = supply_q;
    end
  end

  assign rdata_d = (reg_req_i.rd & en_s) ? read_mux : 8'h00;

  // Host-writable control.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      mode_q      <= MODE_FIELD_RST;
      standby_q   <= STANDBY_RST;
      dev_reset_q <= 1'b0;
      input_sel_q <= INPUT_SEL_RST;
      go_q        <= FIRE_RST;
    end else begin
      if (mode_wr) begin
        mode_q      <= reg_req_i.wdata[MODE_FIELD_MSB:MODE_FIELD_LSB];
        standby_q   <= reg_req_i.wdata[MODE_STANDBY_BIT];
        dev_reset_q <= reg_req_i.wdata[MODE_RESET_BIT];
      end
      if (wr_ok && hit_input) begin
        input_sel_q <= reg_req_i.wdata[INPUT_SEL_BIT];
      end
      go_q <= go_d;
    end
  end

  // Configuration bytes reload on every reset: programmed bytes from storage, the others to CFG_RST.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < CFG_COUNT; i++) begin
      if (clr) begin
        cfg_q[i] <= otp_prog_i[i] ? otp_data_i[i] : CFG_RST;
      end else if (wr_ok && hit_cfg && (cfg_idx == 3'(i))) begin
        cfg_q[i] <= reg_req_i.wdata;
      end
    end
  end

  // Supply measurement, flags and short handling.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      supply_q     <= SUPPLY_RST;
      ot_flag_q    <= 1'b0;
      short_flag_q <= 1'b0;
      block_q      <= 1'b0;
      fault_q      <= 1'b0;
      restart_q    <= 1'b0;
      poll_cnt_q   <= 16'h0000;
    end else begin
      if (supply_valid_i && run_q) begin
        supply_q <= supply_meas_i;
      end
      ot_flag_q <= ot_s;
      if (short_hit) begin
        short_flag_q <= 1'b1;
      end else if (!short_s) begin
        short_flag_q <= 1'b0;
      end
      if (short_early) begin
        block_q <= 1'b1;
      end else if (mode_wr) begin
        block_q <= 1'b0;
      end
      if (short_hit && !short_early) begin
        fault_q <= 1'b1;
      end
      poll_cnt_q <= (fault_q && !poll_wrap) ? poll_cnt_q + 16'h0001 : 16'h0000;
      restart_q  <= poll_wrap & ~short_s;
    end
  end

  // Process, power state and register-port answer.
  always_ff @(posedge clk_i) begin
    if (clr) begin
      run_q         <= 1'b0;
      run_prev_q    <= 1'b0;
      kind_q        <= PROC_NONE;
      drive_en_o    <= 1'b0;
      power_state_o <= PS_SHUTDOWN;
    end else begin
      run_q         <= run_d;
      run_prev_q    <= run_q;
      kind_q        <= run_d ? kind_d : PROC_NONE;
      drive_en_o    <= run_d;
      power_state_o <= pstate_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_ack_o   <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      reg_ack_o   <= reg_req_i.wr | reg_req_i.rd;
      reg_rdata_o <= rdata_d;
    end
  end

  assign proc_o.run  = run_q;
  assign proc_o.kind = kind_q;

endmodule // vdsc_core

// ---- hw/vdsc_pkg.sv ----
package vdsc_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] ADDR_STATUS      = 8'h00;
  localparam logic [7:0] ADDR_MODE        = 8'h01;
  localparam logic [7:0] ADDR_FIRE        = 8'h0C;
  localparam logic [7:0] ADDR_CFG_FIRST   = 8'h16;
  localparam logic [7:0] ADDR_CFG_LAST    = 8'h1A;
  localparam logic [7:0] ADDR_INPUT_CTRL  = 8'h1D;
  localparam logic [7:0] ADDR_SUPPLY      = 8'h21;
  localparam int         CFG_COUNT        = 5;

  // Field positions.
  localparam int STAT_SHORT_BIT     = 0;
  localparam int STAT_OVER_TEMP_BIT = 1;
  localparam int MODE_FIELD_LSB     = 0;
  localparam int MODE_FIELD_MSB     = 2;
  localparam int MODE_STANDBY_BIT   = 6;
  localparam int MODE_RESET_BIT     = 7;
  localparam int FIRE_BIT           = 0;
  localparam int INPUT_SEL_BIT      = 1;

  // Reset values.
  localparam logic [2:0] MODE_FIELD_RST  = 3'h0;
  localparam logic       STANDBY_RST     = 1'b1;
  localparam logic       FIRE_RST        = 1'b0;
  localparam logic       INPUT_SEL_RST   = 1'b0;
  localparam logic [7:0] CFG_RST         = 8'h00;
  localparam logic [7:0] SUPPLY_RST      = 8'h00;

  // Timing: interval between checks of a persisting output short.
  localparam int unsigned CLK_FREQ_MHZ      = 40;
  localparam int unsigned SHORT_POLL_US     = 100;
  localparam int unsigned SHORT_POLL_CYCLES = SHORT_POLL_US * CLK_FREQ_MHZ;

  // Operating-mode field encodings.
  localparam logic [2:0] MODE_INT_TRIG   = 3'h0;
  localparam logic [2:0] MODE_EDGE_TRIG  = 3'h1;
  localparam logic [2:0] MODE_LEVEL_TRIG = 3'h2;
  localparam logic [2:0] MODE_ANALOG_PWM = 3'h3;
  localparam logic [2:0] MODE_REALTIME   = 3'h5;
  localparam logic [2:0] MODE_DIAG       = 3'h6;
  localparam logic [2:0] MODE_CAL        = 3'h7;

  typedef enum logic [2:0] {
    PS_SHUTDOWN,
    PS_STANDBY,
    PS_READY,
    PS_ACTIVE,
    PS_FAULT
  } vdsc_pstate_t;

  typedef enum logic [2:0] {
    PROC_NONE,
    PROC_PLAY,
    PROC_CAL,
    PROC_DIAG,
    PROC_STREAM
  } vdsc_kind_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vdsc_reg_req_t;

  typedef struct packed {
    logic       run;
    vdsc_kind_t kind;
  } vdsc_proc_t;

endpackage

// ---- hw/vdsc_sync.sv ----
module vdsc_sync
  import vdsc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // vdsc_sync

// ---- hw/vdsc_trig.sv ----
module vdsc_trig
  import vdsc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Synchronised trigger pin level
  input  wire logic pin_i,
  // Detected transitions
  output logic      rise_o,
  output logic      fall_o
);

  logic prev_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_i;
    end
  end

  assign rise_o = pin_i & ~prev_q;
  assign fall_o = ~pin_i & prev_q;

endmodule // vdsc_trig

// ---- bench/vdsc_core_assertions.sv ----
module vdsc_core_assertions
  import vdsc_pkg::*;
(
  // Clock and reset
  input wire logic          clk_i,
  input wire logic          rst_n_i,
  // Pins and register port
  input wire logic          enable_pin_i,
  input wire logic          over_temp_i,
  input wire vdsc_reg_req_t reg_req_i,
  input wire logic          reg_ack_o,
  input wire logic    [7:0] reg_rdata_o,
  // Process outputs
  input wire vdsc_proc_t    proc_o,
  input wire logic          drive_en_o,
  input wire vdsc_pstate_t  power_state_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_ack_after_req: assert property ((reg_req_i.wr || reg_req_i.rd) |=> reg_ack_o)
    else $error("request not acknowledged");
  a_ack_needs_req: assert property (reg_ack_o |-> $past(reg_req_i.wr) || $past(reg_req_i.rd))
    else $error("acknowledge without request");
  a_read_off_zero: assert property ((!enable_pin_i [*4] ##0 reg_req_i.rd) |=> reg_rdata_o == 8'h00)
    else $error("read returned data while disabled");
  a_drive_follows_run: assert property (drive_en_o == proc_o.run)
    else $error("drive enable differs from run");
  a_run_means_active: assert property (proc_o.run |-> power_state_o == PS_ACTIVE)
    else $error("process runs outside active state");
  a_overtemp_halts: assert property (over_temp_i [*4] |-> !drive_en_o)
    else $error("output driven while too hot");
  a_enable_off: assert property (!enable_pin_i [*4] |-> power_state_o == PS_SHUTDOWN && !drive_en_o)
    else $error("not shut down with enable low");
  a_standby_halts: assert property ((reg_req_i.wr && reg_req_i.addr == ADDR_MODE
      && reg_req_i.wdata[MODE_STANDBY_BIT]) |=> ##1 !drive_en_o)
    else $error("standby did not stop output");
endmodule // vdsc_core_assertions

bind vdsc_core vdsc_core_assertions u_chk (.clk_i, .rst_n_i, .enable_pin_i, .over_temp_i, .reg_req_i,
  .reg_ack_o, .reg_rdata_o, .proc_o, .drive_en_o, .power_state_o);

// ---- bench/vdsc_host.sv ----
module vdsc_host
  import vdsc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Answer from the register port
  input  wire logic       reg_ack_i,
  input  wire logic [7:0] reg_rdata_i,
  // Request and pins driven by the host
  output vdsc_reg_req_t   req_o,
  output logic            en_o,
  output logic            trig_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_o = '0;
    en_o = 1'b0;
    trig_o = 1'b0;
  end

  // Released address and data are inverted so stale values never look valid.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    req_o = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = reg_ack_i ? reg_rdata_i : 8'hXX;
  endtask

  task automatic set_en(input logic v);
    @(negedge clk_i);
    en_o = v;
  endtask

  // Each pin level is held for n cycles before the task returns.
  task automatic pin(input logic v, input int n);
    @(negedge clk_i);
    trig_o = v;
    repeat (n) @(negedge clk_i);
  endtask
endmodule // vdsc_host

// ---- bench/vibration_driver_state_control_bench.sv ----
module vibration_driver_state_control_bench
  import vdsc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            ot = 1'b0, sd = 1'b0, rs = 1'b0, sv = 1'b0, pd = 1'b0;
  logic      [7:0] sm = 8'h00, q, v, rdata;
  logic      [4:0] op;
  logic [4:0][7:0] od;
  logic            en, trg, ack, de;
  logic      [2:0] ml [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  integer          seed = 36, n_mismatch = 0, n_checks = 0, cyc = 0;
  vdsc_reg_req_t   req;
  vdsc_proc_t      pr;
  vdsc_pstate_t    ps;

  always #12.5 clk_i = ~clk_i;

  vdsc_core #(.POLL_CYCLES(8)) u_dut (.clk_i, .rst_n_i, .enable_pin_i(en), .trigger_input_pin_i(trg),
    .reg_req_i(req), .reg_ack_o(ack), .reg_rdata_o(rdata), .over_temp_i(ot), .short_det_i(sd),
    .reg_short_i(rs), .supply_meas_i(sm), .supply_valid_i(sv), .otp_prog_i(op), .otp_data_i(od),
    .proc_done_i(pd), .proc_o(pr), .drive_en_o(de), .power_state_o(ps));
  vdsc_host u_host (.clk_i, .reg_ack_i(ack), .reg_rdata_i(rdata), .req_o(req), .en_o(en), .trig_o(trg));

  function automatic vdsc_proc_t exp_proc(input logic [2:0] m);
    case (m)
      MODE_ANALOG_PWM, MODE_REALTIME: return '{1'b1, PROC_STREAM};
      MODE_DIAG: return '{1'b1, PROC_DIAG};
      MODE_CAL: return '{1'b1, PROC_CAL};
      3'h4: return '{1'b0, PROC_NONE};
      default: return '{1'b1, PROC_PLAY};
    endcase
  endfunction

  function automatic logic [7:0] cfg_exp(input int i);
    return op[i] ? od[i] : CFG_RST;
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic r(input logic [7:0] a, input logic [7:0] exp);
    u_host.xfer(1'b0, a, 8'h00, q);
    chk(q, exp, "read");
  endtask

  task automatic crun(input logic e);
    chk({7'h00, pr.run}, {7'h00, e}, "run");
    chk({7'h00, de}, {7'h00, e}, "drive");
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out;
    end
  end

  initial begin
    op = 5'($random(seed));
    for (int i = 0; i < CFG_COUNT; i++) od[i] = 8'($random(seed));
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    u_host.set_en(1'b1);
    cyc_n(4);
    r(ADDR_MODE, 8'h40);
    chk(8'(ps), 8'(PS_STANDBY), "state");
    for (int i = 0; i < CFG_COUNT; i++) r(ADDR_CFG_FIRST + 8'(i), cfg_exp(i));
    r(8'h3F, 8'h00);
    u_host.set_en(1'b0);
    cyc_n(4);
    chk(8'(ps), 8'(PS_SHUTDOWN), "state");
    w(ADDR_MODE, 8'h00);
    r(ADDR_MODE, 8'h00);
    u_host.set_en(1'b1);
    cyc_n(4);
    r(ADDR_MODE, 8'h40);
    $display("test power done");
    w(ADDR_INPUT_CTRL, 8'h02);
    r(ADDR_INPUT_CTRL, 8'h02);
    w(ADDR_MODE, 8'h00);
    cyc_n(2);
    chk(8'(ps), 8'(PS_READY), "state");
    foreach (ml[i]) begin
      w(ADDR_MODE, {5'h00, ml[i]});
      cyc_n(2);
      crun(ml[i] == 3'h3 || ml[i] == 3'h5);
      r(ADDR_FIRE, 8'h00);
      w(ADDR_FIRE, 8'h01);
      cyc_n(2);
      chk({4'h0, pr}, {4'h0, exp_proc(ml[i])}, "process");
      w(ADDR_FIRE, 8'h00);
    end
    w(ADDR_MODE, 8'h00);
    w(ADDR_FIRE, 8'h01);
    cyc_n(2);
    crun(1'b1);
    w(ADDR_FIRE, 8'h00);
    cyc_n(2);
    crun(1'b0);
    w(ADDR_FIRE, 8'h01);
    @(negedge clk_i) pd = 1'b1;
    @(negedge clk_i) pd = 1'b0;
    cyc_n(2);
    r(ADDR_FIRE, 8'h00);
    $display("test modes done");
    w(ADDR_MODE, {5'h00, MODE_EDGE_TRIG});
    u_host.pin(1'b1, 3);
    u_host.pin(1'b0, 3);
    r(ADDR_FIRE, 8'h01);
    u_host.pin(1'b1, 3);
    u_host.pin(1'b0, 3);
    r(ADDR_FIRE, 8'h00);
    w(ADDR_MODE, {5'h00, MODE_LEVEL_TRIG});
    u_host.pin(1'b1, 4);
    r(ADDR_FIRE, 8'h01);
    u_host.pin(1'b0, 4);
    r(ADDR_FIRE, 8'h00);
    $display("test trigger done");
    w(ADDR_MODE, {5'h00, MODE_REALTIME});
    v = 8'($random(seed));
    @(negedge clk_i);
    sm = v;
    sv = 1'b1;
    @(negedge clk_i) sv = 1'b0;
    r(ADDR_SUPPLY, v);
    w(ADDR_SUPPLY, ~v);
    r(ADDR_SUPPLY, v);
    ot = 1'b1;
    cyc_n(4);
    crun(1'b0);
    r(ADDR_STATUS, 8'h02);
    ot = 1'b0;
    cyc_n(4);
    r(ADDR_STATUS, 8'h00);
    w(ADDR_MODE, 8'h45);
    cyc_n(1);
    crun(1'b0);
    r(ADDR_MODE, 8'h45);
    w(ADDR_MODE, {5'h00, MODE_REALTIME});
    cyc_n(2);
    crun(1'b1);
    rs = 1'b1;
    cyc_n(4);
    crun(1'b0);
    rs = 1'b0;
    cyc_n(8);
    r(ADDR_MODE, 8'h40);
    v = cfg_exp(0) ^ (8'($random(seed)) | 8'h01);
    w(ADDR_CFG_FIRST, v);
    r(ADDR_CFG_FIRST, v);
    w(ADDR_MODE, 8'h85);
    cyc_n(4);
    r(ADDR_MODE, 8'h40);
    r(ADDR_CFG_FIRST, cfg_exp(0));
    r(ADDR_INPUT_CTRL, 8'h00);
    w(ADDR_MODE, {5'h00, MODE_ANALOG_PWM});
    cyc_n(2);
    chk({4'h0, pr}, {4'h0, exp_proc(MODE_ANALOG_PWM)}, "process");
    chk(8'(ps), 8'(PS_ACTIVE), "state");
    $display("test protection done");
    w(ADDR_MODE, 8'h00);
    sd = 1'b1;
    cyc_n(4);
    r(ADDR_STATUS, 8'h00);
    w(ADDR_FIRE, 8'h01);
    cyc_n(4);
    r(ADDR_STATUS, 8'h01);
    sd = 1'b0;
    cyc_n(4);
    crun(1'b0);
    w(ADDR_MODE, 8'h00);
    w(ADDR_FIRE, 8'h01);
    cyc_n(2);
    crun(1'b1);
    sd = 1'b1;
    cyc_n(4);
    chk(8'(ps), 8'(PS_FAULT), "state");
    sd = 1'b0;
    cyc_n(24);
    r(ADDR_MODE, 8'h40);
    r(ADDR_STATUS, 8'h00);
    $display("test short done");
    close_out;
  end
endmodule // vibration_driver_state_control_bench
